// ===== hdl/flq_pkg.sv
// Functional notes
// R1: Feature bits 2,3,6,7 report supported.
// R2: Feature bits 4,5,8 and reserved read zero.
// R3: Post-suspend byte returns 01.
// R4: Block status mask returns 01 then 00.
// R5: Logic supply byte is BCD, 33.
// R6: Program supply byte returns 00.
// R7: Protection field count byte returns 01.
// R8: Protection descriptor: lock address, log2 sizes.
// R9: Page read byte is log2 size, 03.
// R10: Synchronous read field count returns zero.
// R11: Identifier command write enters identifier mode.
// R12: Identifier reads are separate full cycles.
// R13: Identifier mode lasts until next command.
// R14: Identifier command works at any supply level.
// R15: Identifier command only when machine idle.
// R16: Manufacturer at word 0, device at 1.
// R17: Block offset 2 gives lock on bit0.
// R18: Lowest address line ignored for identifiers.
// R19: Word mode identifier upper byte is zero.
// R20: Extended query starts at 31h with signature.
// R21: Interface descriptor reports x8/x16 asynchronous.
// R22: Reserved lock configuration bits read zero.
// R23: Unassigned identifier addresses read zero.
package flq_pkg;

    // Register byte offsets on the APB side.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // Control and status field positions.
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_READ_BIT  = 1;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_IDMODE_BIT  = 1;
    localparam int ST_REFUSED_BIT = 2;
    localparam int ST_LOCKED_BIT  = 3;
    localparam int ST_STSPIN_BIT  = 4;

    // Flash pin widths.
    localparam int ADDR_W  = 24;
    localparam int WADDR_W = 23;
    localparam int DQ_W    = 16;
    localparam int CMD_W   = 8;

    // Flash commands.
    localparam logic [CMD_W-1:0] CMD_READ_ID    = 8'h90;
    localparam logic [CMD_W-1:0] CMD_READ_ARRAY = 8'hFF;

    // Reset values.
    localparam logic [WADDR_W-1:0] WADDR_RST = 23'h000000;
    localparam logic [CMD_W-1:0]   CMD_RST   = CMD_READ_ARRAY;
    localparam logic [DQ_W-1:0]    DQ_RST    = 16'h0000;
    localparam logic [7:0]         BYTE_ZERO = 8'h00;

    // Flash timing in nanoseconds and the clock period.
    localparam int CLK_PERIOD_NS = 50;
    localparam int READ_ACC_NS   = 150;
    localparam int WE_PULSE_NS   = 70;
    localparam int RECOVER_NS    = 25;
    localparam int SYNC_STAGES   = 2;

    // Least times round up to whole cycles; the read count adds SYNC_STAGES.
    localparam int READ_CYC_I = (READ_ACC_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS + SYNC_STAGES;
    localparam int WE_CYC_I   = (WE_PULSE_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam int REC_CYC_I  = (RECOVER_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam logic [3:0] READ_CYC = 4'(READ_CYC_I);
    localparam logic [3:0] WE_CYC   = 4'(WE_CYC_I);
    localparam logic [3:0] REC_CYC  = 4'(REC_CYC_I);
    localparam logic [3:0] CNT_ONE  = 4'h1;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    // Transfer sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10,
        ST_GAP   = 2'b11
    } flq_state_e;

    // Outputs toward the flash pins.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              ceN;
        logic              oeN;
        logic              weN;
        logic [DQ_W-1:0]   dqOut;
        logic              dqOe;
    } flq_pins_s;

    localparam flq_pins_s PINS_RST = '{addr: 24'h000000, ceN: 1'b1,
                                       oeN: 1'b1, weN: 1'b1,
                                       dqOut: 16'h0000, dqOe: 1'b0};

endpackage

// ===== hdl/flq_host_ctrl.sv
`timescale 1ns/1ps
module flq_host_ctrl
    import flq_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    output flq_pins_s              flashPins,
    input  wire logic [DQ_W-1:0]   flashDqIn,
    input  wire logic              flashSts
);

    flq_state_e         state, next_state;
    logic [3:0]         cnt, next_cnt;
    logic [WADDR_W-1:0] wordAddr, next_wordAddr;
    logic [CMD_W-1:0]   cmd, next_cmd;
    logic [DQ_W-1:0]    rdData, next_rdData;
    logic               idMode, next_idMode;
    logic               refused, next_refused;
    logic               locked, next_locked;
    logic               opRead, next_opRead;
    flq_pins_s          pins, next_pins;
    logic               pready_q, next_pready;
    logic [31:0]        prdata_q, next_prdata;
    logic               pslverr_q, next_pslverr;
    logic [DQ_W-1:0]    dqSync1, dqSync2;
    logic               stsSync1, stsSync2;
    logic               setup, wrSetup, rdSetup, start, busy;

    // Pin inputs pass two flip-flops before any logic reads them.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            dqSync1  <= DQ_RST;
            dqSync2  <= DQ_RST;
            stsSync1 <= 1'b0;
            stsSync2 <= 1'b0;
        end
        else
        begin
            dqSync1  <= flashDqIn;
            dqSync2  <= dqSync1;
            stsSync1 <= flashSts;
            stsSync2 <= stsSync1;
        end
    end

    // Decode the APB setup cycle; answers come one cycle later.
    assign setup   = psel && !penable;
    assign wrSetup = setup && pwrite;
    assign rdSetup = setup && !pwrite;
    assign busy    = (state != ST_IDLE);
    assign start   = wrSetup && (paddr == REG_CTRL)
                     && pwdata[CTRL_START_BIT] && !busy;

    // Next values of the APB slave, the registers and the sequencer.
    always_comb
    begin
        next_state    = state;
        next_cnt      = cnt;
        next_wordAddr = wordAddr;
        next_cmd      = cmd;
        next_rdData   = rdData;
        next_idMode   = idMode;
        next_refused  = refused;
        next_locked   = locked;
        next_opRead   = opRead;
        next_pins     = pins;
        next_pready   = setup;
        next_prdata   = 32'h00000000;
        next_pslverr  = 1'b0;

        // Software writes to the address and command registers.
        if (wrSetup && !busy && paddr == REG_ADDR)
        begin
            next_wordAddr = pwdata[WADDR_W-1:0];
        end
        if (wrSetup && !busy && paddr == REG_WDATA)
        begin
            next_cmd = pwdata[CMD_W-1:0];
        end
        if (setup && !(paddr == REG_CTRL || paddr == REG_ADDR
                       || paddr == REG_WDATA || paddr == REG_RDATA
                       || paddr == REG_STATUS))
        begin
            next_pslverr = 1'b1;
        end

        // Read data for the APB access phase.
        if (rdSetup)
        begin
            case (paddr)
                REG_ADDR:   next_prdata = {9'h000, wordAddr};
                REG_WDATA:  next_prdata = {24'h000000, cmd};
                REG_RDATA:  next_prdata = {16'h0000, rdData};
                REG_STATUS:
                begin
                    next_prdata[ST_BUSY_BIT]    = busy;
                    next_prdata[ST_IDMODE_BIT]  = idMode;
                    next_prdata[ST_REFUSED_BIT] = refused;
                    next_prdata[ST_LOCKED_BIT]  = locked;
                    next_prdata[ST_STSPIN_BIT]  = stsSync2;
                end
                default:    next_prdata = 32'h00000000;
            endcase
        end

        // Flash cycle sequencer.
        case (state)
            ST_IDLE:
            begin
                if (start)
                begin
                    next_refused = 1'b0;
                    next_opRead  = pwdata[CTRL_READ_BIT];
                    // Lowest line held low so identifiers use A1 up. see R18
                    next_pins.addr = {wordAddr, 1'b0};
                    next_pins.ceN  = 1'b0;
                    if (pwdata[CTRL_READ_BIT])
                    begin
                        // Each read is a full cycle with fresh enables. see R12
                        next_pins.oeN = 1'b0;
                        next_cnt      = READ_CYC;
                        next_state    = ST_READ;
                    end
                    else if (cmd == CMD_READ_ID && !stsSync2)
                    begin
                        // Machine busy: identifier command held back. see R15
                        next_refused  = 1'b1;
                        next_pins.ceN = 1'b1;
                    end
                    else
                    begin
                        // Supply level is not checked for this command. see R14
                        next_pins.weN   = 1'b0;
                        next_pins.dqOut = {BYTE_ZERO, cmd};
                        next_pins.dqOe  = 1'b1;
                        next_cnt        = WE_CYC;
                        next_state      = ST_WRITE;
                        // Mode follows the last accepted command. see R11 R13
                        next_idMode     = (cmd == CMD_READ_ID);
                    end
                end
            end
            ST_READ:
            begin
                if (cnt == CNT_ONE)
                begin
                    // Identifier data sits in the low byte only. see R19 R22
                    next_rdData = idMode ? {BYTE_ZERO, dqSync2[7:0]}
                                         : dqSync2;
                    if (idMode)
                    begin
                        next_locked = dqSync2[0]; // see R17
                    end
                    next_pins.oeN = 1'b1;
                    next_pins.ceN = 1'b1;
                    next_cnt      = REC_CYC;
                    next_state    = ST_GAP;
                end
                else
                begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            ST_WRITE:
            begin
                if (cnt == CNT_ONE)
                begin
                    next_pins.weN = 1'b1;
                    next_pins.ceN = 1'b1;
                    next_cnt      = REC_CYC;
                    next_state    = ST_GAP;
                end
                else
                begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            ST_GAP:
            begin
                // Data is released only after the strobe has risen.
                next_pins.dqOe = 1'b0;
                if (cnt <= CNT_ONE)
                begin
                    next_cnt   = CNT_ZERO;
                    next_state = ST_IDLE;
                end
                else
                begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            default:
            begin
                next_pins  = PINS_RST;
                next_state = ST_IDLE;
            end
        endcase
    end

    // Register every piece of state.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state     <= ST_IDLE;
            cnt       <= CNT_ZERO;
            wordAddr  <= WADDR_RST;
            cmd       <= CMD_RST;
            rdData    <= DQ_RST;
            idMode    <= 1'b0;
            refused   <= 1'b0;
            locked    <= 1'b0;
            opRead    <= 1'b0;
            pins      <= PINS_RST;
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            wordAddr  <= next_wordAddr;
            cmd       <= next_cmd;
            rdData    <= next_rdData;
            idMode    <= next_idMode;
            refused   <= next_refused;
            locked    <= next_locked;
            opRead    <= next_opRead;
            pins      <= next_pins;
            pready_q  <= next_pready;
            prdata_q  <= next_prdata;
            pslverr_q <= next_pslverr;
        end
    end

    // Outputs come straight from flip-flops.
    assign pready    = pready_q;
    assign prdata    = prdata_q;
    assign pslverr   = pslverr_q;
    assign flashPins = pins;

endmodule // flq_host_ctrl

// ===== tb/flq_host_ctrl_chk.sv
`timescale 1ns/1ps
// Checks the flash pin sequences.
module flq_host_ctrl_chk
    import flq_pkg::*;
(
    input wire logic      clk,
    input wire logic      resetn,
    input wire flq_pins_s flashPins,
    input wire logic      flashSts
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_WE_LEN: assert property (
        $fell(flashPins.weN) |=> !flashPins.weN ##1 flashPins.weN)
        else $error("bad strobe length");
    AST_CMD_WORD: assert property (
        !flashPins.weN |-> flashPins.dqOe && !flashPins.ceN
        && flashPins.oeN && flashPins.dqOut[15:8] == 8'h00)
        else $error("bad command cycle");
    AST_RD_LEN: assert property (
        $fell(flashPins.oeN) |-> (!flashPins.oeN)[*5] ##1 flashPins.oeN)
        else $error("bad read length");
    AST_RD_ADDR: assert property (
        !flashPins.oeN |=> flashPins.oeN || $stable(flashPins.addr))
        else $error("address moved in read");
    cover property ($fell(flashPins.weN));
    cover property ($fell(flashPins.oeN));
    cover property ($rose(flashSts));
endmodule // flq_host_ctrl_chk
bind flq_host_ctrl flq_host_ctrl_chk u_flq_host_ctrl_chk (.clk(clk),
    .resetn(resetn), .flashPins(flashPins), .flashSts(flashSts));

// ===== tb/flq_flash_model.sv
`timescale 1ns/1ps
// Flash beside the controller: array and identifier reads.
module flq_flash_model
    import flq_pkg::*;
#(
    parameter int           ACC_NS = 100,
    parameter logic [7:0]   MFR    = 8'hA5, // Arbitrary value.
    parameter logic [7:0]   DEV    = 8'h3C, // Arbitrary value.
    parameter logic [7:0]   QRY_CMD    = 8'h98,
    parameter logic [7:0]   PR_LOCK_HI = 8'h00,
    parameter logic [7:0]   PR_FACT_N  = 8'h03,
    parameter logic [7:0]   PR_USER_N  = 8'h03,
    parameter logic [127:0] LOCKS  = 128'h8
)
(
    input  wire flq_pins_s  pins,
    input  wire logic       machBusy,
    output logic [DQ_W-1:0] dq,
    output logic            sts
);
    logic               idMode = 1'b0;
    logic               qryMode = 1'b0;
    logic [WADDR_W-1:0] wa;
    logic [DQ_W-1:0]    val;
    // The lowest address line is not decoded; ready is the inverse of busy.
    assign wa = pins.addr[ADDR_W-1:1];
    assign sts = !machBusy;
    // Commands latch as the strobe rises; a busy machine takes none.
    always @(posedge pins.weN)
        if (!machBusy)
        begin
            idMode  <= pins.dqOut[7:0] == CMD_READ_ID;
            qryMode <= pins.dqOut[7:0] == QRY_CMD;
        end
    // Extended query bytes by word offset; unlisted offsets read zero.
    function automatic logic [7:0] qry(input logic [7:0] off);
        case (off)
            8'h28:   qry = 8'h02;
            8'h31:   qry = 8'h50;
            8'h32:   qry = 8'h52;
            8'h33:   qry = 8'h49;
            8'h36:   qry = 8'hCE;      // Bits 1,2,3,6,7 set.
            8'h3A:   qry = 8'h01;
            8'h3B:   qry = 8'h01;
            8'h3D:   qry = 8'h33;
            8'h3F:   qry = 8'h01;
            8'h41:   qry = PR_LOCK_HI;
            8'h42:   qry = PR_FACT_N;
            8'h43:   qry = PR_USER_N;
            8'h44:   qry = 8'h03;
            default: qry = 8'h00;
        endcase
    endfunction
    // Identifier data sits on the low byte, zero where unassigned.
    always_comb
        if (qryMode)
            val = {8'h00, qry(wa[7:0])};
        else if (!idMode)
            val = ~wa[15:0];
        else if (wa < 2)
            val = {8'h00, wa[0] ? DEV : MFR};
        else if (wa[15:0] == 16'h0002)
            val = {15'h0000, LOCKS[wa[22:16]]};
        else
            val = 16'h0000;
    // Data after the access time; released lines show the inverse.
    always @(pins.oeN, pins.ceN, val)
        if (!pins.oeN && !pins.ceN)
            dq <= #ACC_NS val;
        else
            dq <= #ACC_NS ~dq;
endmodule // flq_flash_model

// ===== tb/flq_host_ctrl_bench.sv
`timescale 1ns/1ps
module flq_host_ctrl_bench
    import flq_pkg::*;
();
    logic        clk = 1'b0, resetn = 1'b0, busy = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, sts;
    logic [7:0]  paddr = 8'h00;
    logic [15:0] dq;
    logic [31:0] pwdata = 32'h0, prdata, r;
    flq_pins_s   pins;
    int          errTotal = 0, checkCount = 0;
    localparam logic [7:0] QRY = 8'h98; // Query command code.
    // Clock and the units under test.
    always #25 clk = ~clk;
    flq_host_ctrl u_flq_host_ctrl (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .flashPins(pins),
        .flashDqIn(dq), .flashSts(sts));
    flq_flash_model #(.ACC_NS(140), .QRY_CMD(QRY)) u_flq_flash_model (
        .pins(pins), .machBusy(busy), .dq(dq), .sts(sts));
    // One transfer; the error flag is folded into bit 0 of the result.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata | 32'(pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Counts a comparison and reports a mismatch.
    task automatic chk(input string n, input logic [31:0] x);
        checkCount++;
        if (r !== x)
        begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", n, x, r);
        end
    endtask
    // Runs one flash transfer, polls until idle, checks data or status.
    task automatic op(input logic rd, input logic [22:0] v,
        input logic [31:0] x, input string n);
        apb(1'b1, rd ? REG_ADDR : REG_WDATA, {9'h000, v});
        apb(1'b1, REG_CTRL, {30'h0, rd, 1'b1});
        do apb(1'b0, REG_STATUS, 32'h0); while (r[ST_BUSY_BIT] !== 1'b0);
        if (rd)
            apb(1'b0, REG_RDATA, 32'h0);
        chk(n, x);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic closeOut;
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Cuts a hang short.
    initial
    begin
        #2000000;
        errTotal++;
        closeOut;
    end
    // Identifier mode, query mode, then commands refused and taken by ready state.
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h1);
        op(1'b1, 23'h5, 32'hFFFA, "array word");
        op(1'b0, 23'h90, 32'h12, "id on");
        op(1'b1, 23'h0, 32'hA5, "maker");
        op(1'b1, 23'h1, 32'h3C, "device");
        op(1'b1, 23'h30002, 32'h1, "locked block");
        apb(1'b0, REG_STATUS, 32'h0);
        chk("lock flag", 32'h1A);
        op(1'b1, 23'h2, 32'h0, "open block");
        op(1'b1, 23'h5, 32'h0, "unassigned");
        op(1'b0, 23'hFF, 32'h10, "id off");
        $display("test identifier done");
        op(1'b0, {15'h0000, QRY}, 32'h10, "query on");
        op(1'b1, 23'h28, 32'h02, "interface");
        op(1'b1, 23'h31, 32'h50, "signature first");
        op(1'b1, 23'h33, 32'h49, "signature last");
        op(1'b1, 23'h36, 32'hCE, "features low");
        op(1'b1, 23'h37, 32'h00, "features high");
        op(1'b1, 23'h3A, 32'h01, "after suspend");
        op(1'b1, 23'h3B, 32'h01, "status mask low");
        op(1'b1, 23'h3C, 32'h00, "status mask high");
        op(1'b1, 23'h3D, 32'h33, "logic supply");
        op(1'b1, 23'h3E, 32'h00, "program supply");
        op(1'b1, 23'h3F, 32'h01, "protection count");
        op(1'b1, 23'h40, 32'h00, "lock address low");
        op(1'b1, 23'h44, 32'h03, "page size");
        op(1'b1, 23'h45, 32'h00, "burst fields");
        op(1'b0, 23'hFF, 32'h10, "query off");
        $display("test query done");
        busy <= 1'b1;
        repeat (4) @(posedge clk);
        op(1'b0, 23'h90, 32'h4, "refused");
        busy <= 1'b0;
        repeat (4) @(posedge clk);
        op(1'b0, 23'h90, 32'h12, "accepted");
        $display("test busy done");
        closeOut;
    end
endmodule // flq_host_ctrl_bench
